/* File: aos_pkg.sv */
/*
 * aos_pkg: constants, register map and mode encodings shared by the
 * adder/output stage of the hard multiply block.
 * assumes: 32-bit apb with byte addresses, products arrive already formed.
 */
package aos_pkg;
   // ----------------------------------------------------------------------
   // datapath widths
   // ----------------------------------------------------------------------
   localparam int PW = 36;
   localparam int HW = 18;
   localparam int ACC_W = 52;
   localparam int GUARD_W = 16;
   localparam int EXT_W = 54;
   localparam int PAIR_W = 72;
   localparam int LANES = 4;
   localparam int OUT_W = 144;
   localparam int AW = 8;
   localparam int DW = 32;
   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PIPE = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_NINE = 2;
   localparam int CTRL_WIDE = 3;
   localparam int CTRL_OREG_LSB = 4;
   localparam int PIPE_ANS_LSB = 0;
   localparam int PIPE_SGN_LSB = 2;
   localparam int PIPE_SLD_LSB = 4;
   localparam int PIPE_OSET_LSB = 8;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] PIPE_RST = 16'he400;
   // ----------------------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------------------
   localparam logic [1:0] MCODE_SIMPLE = 2'h0;
   localparam logic [1:0] MCODE_MAC = 2'h1;
   localparam logic [1:0] MCODE_ADD2 = 2'h2;
   localparam logic [1:0] MCODE_ADD4 = 2'h3;
   typedef enum logic [3:0] {
      AOS_SIMPLE = 4'h1,
      AOS_MAC = 4'h2,
      AOS_ADD2 = 4'h4,
      AOS_ADD4 = 4'h8
   } aos_mode_t;
endpackage : aos_pkg

/* File: aos_adder_output_stage.sv */
/*
 * aos_adder_output_stage: first-level adder/subtractor/accumulators,
 * summation, output selection and optional output registers of a hard
 * multiply block, configured over apb.
 * assumes: products come from the block's own multiplier sub-blocks on
 * mclk; control inputs are driven by logic on mclk.
 */
// What this block does
// RQ1 - accumulator mode always uses the output registers
// RQ2 - only own multiplier products enter the stage
// RQ3 - add when select high, subtract when low
// RQ4 - two selects; nine-bit mode shares each by pairs
// RQ5 - add/subtract select delayed zero, one or two
// RQ6 - sign controls shared, delayed zero to two
// RQ7 - synchronous load replaces total with current product
// RQ8 - registered, non-sticky overflow/underflow flag per accumulator
// RQ9 - registered output fed back into accumulator
// RQ10 - summation adds first-level results, one or two sums
// RQ11 - output mux picks product, adder or sum
// RQ12 - output registers optional, four enable/clear sets
// RQ13 - exactly one of four modes at once
// RQ14 - simple mode passes products straight out
// RQ15 - wide product built from four partial products
// RQ16 - accumulators fed by second and fourth multipliers
// RQ17 - accumulator is 52 bits with 16 guard
// RQ18 - load and overflow only in accumulate mode
// RQ19 - two-multiplier adder gives two or four results
// RQ20 - complex product uses one subtractor, one adder
// RQ21 - four units, two sums in nine-bit mode
// RQ22 - sign high means signed; either signed gives signed
// RQ23 - accumulator adds or subtracts product each step
`timescale 1ns/1ns
`default_nettype none
module aos_adder_output_stage (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [aos_pkg::AW-1:0] paddr,
   input wire logic [aos_pkg::DW-1:0] pwdata,
   output logic [aos_pkg::DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [aos_pkg::PW-1:0] prod_0,
   input wire logic [aos_pkg::PW-1:0] prod_1,
   input wire logic [aos_pkg::PW-1:0] prod_2,
   input wire logic [aos_pkg::PW-1:0] prod_3,
   input wire logic sign_a,
   input wire logic sign_b,
   input wire logic [1:0] addnsub,
   input wire logic [1:0] sload,
   input wire logic [3:0] ena,
   input wire logic [3:0] clr,
   output logic [aos_pkg::OUT_W-1:0] result,
   output logic [1:0] overflow
);
   import aos_pkg::*;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [1:0] aos_pick(input logic [1:0] depth,
         input logic [1:0] s0, input logic [1:0] s1, input logic [1:0] s2);
      logic [1:0] r;
      r = s2;
      if (depth == 2'h0) begin
         r = s0;
      end else if (depth == 2'h1) begin
         r = s1;
      end
      return r;
   endfunction : aos_pick

   // ----------------------------------------------------------------------
   // apb register file
   // ----------------------------------------------------------------------
   logic [7:0] ctrl;
   logic [15:0] pipe;
   logic [1:0] ovf;
   aos_mode_t mode;
   wire hit_ctrl = (paddr == OFS_CTRL);
   wire hit_pipe = (paddr == OFS_PIPE);
   wire hit_stat = (paddr == OFS_STAT);
   wire hit = hit_ctrl | hit_pipe | hit_stat;
   wire acc_phase = psel & penable;
   wire wr_go = acc_phase & pwrite & hit;
   logic [DW-1:0] rd_mux;

   assign pready = 1'b1;
   assign pslverr = acc_phase & ~hit;
   assign rd_mux = hit_ctrl ? {24'h000000, ctrl} :
                   hit_pipe ? {16'h0000, pipe} :
                   hit_stat ? {26'h0000000, mode, ovf} : 32'h00000000;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= CTRL_RST;
         pipe <= PIPE_RST;
         prdata <= 32'h00000000;
      end else begin
         if (wr_go && hit_ctrl) begin
            ctrl <= pwdata[7:0];
         end
         if (wr_go && hit_pipe) begin
            pipe <= pwdata[15:0];
         end
         // read data captured in setup so the access phase needs no wait
         if (psel && !penable) begin
            prdata <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------------
   wire [1:0] mcode = ctrl[CTRL_MODE_LSB +: 2];
   wire nine = ctrl[CTRL_NINE];
   wire [3:0] oreg = ctrl[CTRL_OREG_LSB +: 4];

   always_comb begin
      // a two-bit code can only name one mode at a time (see RQ13)
      unique case (mcode)
         MCODE_SIMPLE: mode = AOS_SIMPLE;
         MCODE_MAC: mode = AOS_MAC;
         MCODE_ADD2: mode = AOS_ADD2;
         MCODE_ADD4: mode = AOS_ADD4;
      endcase
   end

   wire mac = (mode == AOS_MAC);
   wire wide = ctrl[CTRL_WIDE] & (mode == AOS_SIMPLE);

   // ----------------------------------------------------------------------
   // control pipelines
   // ----------------------------------------------------------------------
   logic [5:0] cst1;
   logic [5:0] cst2;
   wire [5:0] cst0 = {sload, sign_b, sign_a, addnsub};

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cst1 <= 6'h00;
         cst2 <= 6'h00;
      end else begin
         cst1 <= cst0;
         cst2 <= cst1;
      end
   end

   wire [1:0] ans_eff = aos_pick(pipe[PIPE_ANS_LSB +: 2], cst0[1:0], cst1[1:0],
                                 cst2[1:0]); // see RQ5
   wire [1:0] sgn_eff = aos_pick(pipe[PIPE_SGN_LSB +: 2], cst0[3:2], cst1[3:2],
                                 cst2[3:2]); // see RQ6
   wire [1:0] sld_raw = aos_pick(pipe[PIPE_SLD_LSB +: 2], cst0[5:4], cst1[5:4],
                                 cst2[5:4]); // see RQ7
   // load exists only while accumulating
   wire [1:0] sld_eff = sld_raw & {2{mac}}; // see RQ18
   wire sgn = sgn_eff[0] | sgn_eff[1]; // see RQ22

   // ----------------------------------------------------------------------
   // product extension
   // ----------------------------------------------------------------------
   // nothing but the sub-block products and the fed-back totals feeds the adders
   logic [PW-1:0] p [LANES]; // see RQ2
   logic [EXT_W-1:0] e18 [LANES];
   logic [EXT_W-1:0] e9 [2*LANES];
   logic [PW-1:0] out_q [LANES];
   logic [ACC_W-1:0] acc [2];
   logic [EXT_W-1:0] acc_ext [2];
   assign p[0] = prod_0;
   assign p[1] = prod_1;
   assign p[2] = prod_2;
   assign p[3] = prod_3;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_ext
         assign e18[g] = {{(EXT_W-PW){sgn & p[g][PW-1]}}, p[g]}; // see RQ22
         assign e9[2*g] = {{(EXT_W-HW){sgn & p[g][HW-1]}}, p[g][HW-1:0]};
         assign e9[2*g+1] = {{(EXT_W-HW){sgn & p[g][PW-1]}}, p[g][PW-1:HW]};
      end
      for (g = 0; g < 2; g++) begin : g_fb
         // total read back from the registered lanes (see RQ9)
         assign acc[g] = {out_q[2*g+1][ACC_W-PW-1:0], out_q[2*g]};
         assign acc_ext[g] = {{(EXT_W-ACC_W){sgn & acc[g][ACC_W-1]}}, acc[g]};
      end
   endgenerate

   // ----------------------------------------------------------------------
   // first-level adder/subtractor/accumulators
   // ----------------------------------------------------------------------
   logic [EXT_W-1:0] ux [LANES];
   logic [EXT_W-1:0] uy [LANES];
   logic [EXT_W-1:0] ur [LANES];
   logic [LANES-1:0] uadd;

   generate
      for (g = 0; g < LANES; g++) begin : g_unit
         if (g < 2) begin : g_lo
            // accumulators take sub-blocks 1 and 3 only (see RQ16)
            assign ux[g] = mac ? (sld_eff[g] ? {EXT_W{1'b0}} : acc_ext[g]) :
                           nine ? e9[2*g] : e18[2*g]; // see RQ7
            assign uy[g] = (nine && !mac) ? e9[2*g+1] : e18[2*g+1];
            assign uadd[g] = sld_eff[g] | (nine && !mac ? ans_eff[0] : ans_eff[g]); // see RQ4
         end else begin : g_hi
            // upper pair of units only exists in nine-bit mode (see RQ21)
            assign ux[g] = (nine && !mac) ? e9[2*g] : {EXT_W{1'b0}};
            assign uy[g] = (nine && !mac) ? e9[2*g+1] : {EXT_W{1'b0}};
            assign uadd[g] = ans_eff[1]; // see RQ4
         end
         // high select adds, low subtracts (see RQ3, RQ20, RQ23)
         assign ur[g] = uadd[g] ? ux[g] + uy[g] : ux[g] - uy[g];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // overflow detection
   // ----------------------------------------------------------------------
   // signed: top bit of the 52-bit total and the bits above disagree; unsigned: any carry
   // or borrow out of the total (see RQ17)
   logic [1:0] ovf_hit;
   generate
      for (g = 0; g < 2; g++) begin : g_ovf
         assign ovf_hit[g] = sgn ?
            (ur[g][EXT_W-1:ACC_W-1] != 3'h0 && ur[g][EXT_W-1:ACC_W-1] != 3'h7) :
            (ur[g][EXT_W-1:ACC_W] != 2'h0);
      end
   endgenerate

   // ----------------------------------------------------------------------
   // summation and wide product
   // ----------------------------------------------------------------------
   wire [EXT_W-1:0] sum0 = ur[0] + ur[1]; // see RQ10
   wire [EXT_W-1:0] sum1 = ur[2] + ur[3]; // see RQ10
   // partial products: 0 lo*lo, 1 hi(a)*lo(b), 2 lo(a)*hi(b), 3 hi*hi
   wire [PAIR_W-1:0] mid72 = {{PW{sgn_eff[0] & p[1][PW-1]}}, p[1]} +
                             {{PW{sgn_eff[1] & p[2][PW-1]}}, p[2]};
   wire [PAIR_W-1:0] wide72 = {p[3], {PW{1'b0}}} + {mid72[PAIR_W-HW-1:0], {HW{1'b0}}} +
                              {{PW{1'b0}}, p[0]}; // see RQ15

   // ----------------------------------------------------------------------
   // output selection
   // ----------------------------------------------------------------------
   logic [PAIR_W-1:0] lo72;
   logic [PAIR_W-1:0] hi72;
   logic [PW-1:0] next_lane [LANES];
   wire [PAIR_W-1:0] s0x = {{(PAIR_W-EXT_W){sgn & sum0[EXT_W-1]}}, sum0};
   wire [PAIR_W-1:0] s1x = {{(PAIR_W-EXT_W){sgn & sum1[EXT_W-1]}}, sum1};
   wire [PAIR_W-1:0] u0x = {{(PAIR_W-EXT_W){sgn & ur[0][EXT_W-1]}}, ur[0]};
   wire [PAIR_W-1:0] u1x = {{(PAIR_W-EXT_W){sgn & ur[1][EXT_W-1]}}, ur[1]};
   wire [PAIR_W-1:0] a0x = {{(PAIR_W-ACC_W){sgn & ur[0][ACC_W-1]}}, ur[0][ACC_W-1:0]};
   wire [PAIR_W-1:0] a1x = {{(PAIR_W-ACC_W){sgn & ur[1][ACC_W-1]}}, ur[1][ACC_W-1:0]};

   always_comb begin
      lo72 = {p[1], p[0]};
      hi72 = {p[3], p[2]};
      unique case (mode)
         AOS_SIMPLE: begin
            // products straight through, or the combined wide one
            lo72 = wide ? wide72 : {p[1], p[0]}; // see RQ14
            hi72 = wide ? {PAIR_W{1'b0}} : {p[3], p[2]}; // see RQ15
         end
         AOS_MAC: begin
            lo72 = a0x; // see RQ11
            hi72 = a1x;
         end
         AOS_ADD2: begin
            // nine-bit results fit a lane each (see RQ19)
            lo72 = nine ? {ur[1][PW-1:0], ur[0][PW-1:0]} : u0x;
            hi72 = nine ? {ur[3][PW-1:0], ur[2][PW-1:0]} : u1x;
         end
         AOS_ADD4: begin
            lo72 = s0x; // see RQ11
            hi72 = nine ? s1x : {PAIR_W{1'b0}};
         end
      endcase
   end

   assign next_lane[0] = lo72[PW-1:0];
   assign next_lane[1] = lo72[PAIR_W-1:PW];
   assign next_lane[2] = hi72[PW-1:0];
   assign next_lane[3] = hi72[PAIR_W-1:PW];

   // ----------------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------------
   logic [1:0] lset [LANES];
   logic [LANES-1:0] lane_en;
   logic [LANES-1:0] lane_clr;
   logic [LANES-1:0] lane_reg;

   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         // an accumulator's two lanes share one control set
         assign lset[g] = mac ? pipe[PIPE_OSET_LSB + 2*(g & 2) +: 2] :
                          pipe[PIPE_OSET_LSB + 2*g +: 2]; // see RQ12
         assign lane_en[g] = ena[lset[g]];
         assign lane_clr[g] = clr[lset[g]];
         assign lane_reg[g] = oreg[g] | mac; // see RQ1
         assign result[PW*g +: PW] = lane_reg[g] ? out_q[g] : next_lane[g]; // see RQ12
      end
   endgenerate

   // clear is sampled on mclk: one clock only, so no extra reset trees
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < LANES; i++) begin
            out_q[i] <= {PW{1'b0}};
         end
         ovf <= 2'h0;
      end else begin
         for (int i = 0; i < LANES; i++) begin
            if (lane_clr[i]) begin
               out_q[i] <= {PW{1'b0}};
            end else if (lane_en[i]) begin
               out_q[i] <= next_lane[i]; // see RQ9
            end
         end
         for (int i = 0; i < 2; i++) begin
            // current-step flag only, held while the lane enable is low (see RQ8, RQ18)
            if (lane_clr[2*i]) begin
               ovf[i] <= 1'b0;
            end else if (lane_en[2*i]) begin
               ovf[i] <= mac & ~sld_eff[i] & ovf_hit[i];
            end
         end
      end
   end

   assign overflow = ovf;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   sequence s_step0;
      mac && lane_en[0] && !lane_clr[0];
   endsequence

   property p_mac_regs;
      @(posedge mclk) disable iff (!rst_b)
      mac |-> lane_reg[0] && lane_reg[1] && result[PW-1:0] == out_q[0];
   endproperty
   a_mac_regs: assert property (p_mac_regs) else $error("accumulator unregistered"); // see RQ1

   property p_add_sub;
      @(posedge mclk) disable iff (!rst_b)
      (mode == AOS_ADD2 && !nine && !ans_eff[0]) |-> ur[0] == e18[0] - e18[1];
   endproperty
   a_add_sub: assert property (p_add_sub) else $error("subtract not taken"); // see RQ3

   property p_ans_pipe;
      @(posedge mclk) disable iff (!rst_b)
      (pipe[PIPE_ANS_LSB +: 2] == 2'h2 && $past(rst_b, 2)) |-> ans_eff == $past(addnsub, 2);
   endproperty
   a_ans_pipe: assert property (p_ans_pipe) else $error("select delay wrong"); // see RQ5

   property p_load;
      @(posedge mclk) disable iff (!rst_b)
      (s_step0 and sld_eff[0]) |=> acc[0] == $past(e18[1][ACC_W-1:0]);
   endproperty
   a_load: assert property (p_load) else $error("load lost"); // see RQ7

   property p_accum;
      @(posedge mclk) disable iff (!rst_b)
      (s_step0 and (!sld_eff[0] && ans_eff[0])) |=>
         acc[0] == $past(acc[0]) + $past(e18[1][ACC_W-1:0]);
   endproperty
   a_accum: assert property (p_accum) else $error("accumulate wrong"); // see RQ23

   property p_ovf;
      @(posedge mclk) disable iff (!rst_b)
      (s_step0 and (!sld_eff[0] && ovf_hit[0])) |=> overflow[0] ##1 (overflow[0] == $past(ovf_hit[0] && lane_en[0] && mac && !lane_clr[0] && !sld_eff[0]) || !$past(lane_en[0]) || $past(lane_clr[0]));
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag wrong"); // see RQ8

   property p_no_ovf;
      @(posedge mclk) disable iff (!rst_b)
      (!mac && lane_en[0]) |=> !overflow[0];
   endproperty
   a_no_ovf: assert property (p_no_ovf) else $error("overflow outside mac"); // see RQ18

   property p_sum;
      @(posedge mclk) disable iff (!rst_b)
      (mode == AOS_ADD4 && !lane_reg[0]) |-> result[PW-1:0] == s0x[PW-1:0];
   endproperty
   a_sum: assert property (p_sum) else $error("sum not routed"); // see RQ10

   property p_simple;
      @(posedge mclk) disable iff (!rst_b)
      (mode == AOS_SIMPLE && !wide && !lane_reg[2]) |-> result[3*PW-1:2*PW] == prod_2;
   endproperty
   a_simple: assert property (p_simple) else $error("product not passed"); // see RQ14

   property p_clear;
      @(posedge mclk) disable iff (!rst_b)
      lane_clr[3] |=> out_q[3] == {PW{1'b0}};
   endproperty
   a_clear: assert property (p_clear) else $error("lane clear ignored"); // see RQ12
endmodule : aos_adder_output_stage
`default_nettype wire

/* File: aos_mult_model.sv */
/*
 * aos_mult_model: behavioural model of the multiplier sub-blocks that feed
 * the adder/output stage, four full-precision 18x18 products.
 * assumes: operands and sign controls come from the bench on mclk edges;
 * products settle combinationally, as if the post-multiply register is off.
 */
`timescale 1ns/1ns
`default_nettype none
module aos_mult_model (
   input wire logic [3:0][aos_pkg::HW-1:0] op_a,
   input wire logic [3:0][aos_pkg::HW-1:0] op_b,
   input wire logic sign_a,
   input wire logic sign_b,
   output logic [aos_pkg::PW-1:0] prod_0,
   output logic [aos_pkg::PW-1:0] prod_1,
   output logic [aos_pkg::PW-1:0] prod_2,
   output logic [aos_pkg::PW-1:0] prod_3
);
   import aos_pkg::*;
   // ----------------------------------------------------------------------
   // products
   // ----------------------------------------------------------------------
   logic [3:0][PW-1:0] ext_a;
   logic [3:0][PW-1:0] ext_b;
   logic [3:0][PW-1:0] full;
   for (genvar k = 0; k < LANES; k++) begin : g_lane
      assign ext_a[k] = sign_a ? {{HW{op_a[k][HW-1]}}, op_a[k]} : {{HW{1'b0}}, op_a[k]};
      assign ext_b[k] = sign_b ? {{HW{op_b[k][HW-1]}}, op_b[k]} : {{HW{1'b0}}, op_b[k]};
      // low bits of the wide product are exact for mixed signedness
      assign full[k] = PW'(ext_a[k] * ext_b[k]);
   end
   // one pair of sign controls serves every sub-block
   assign prod_0 = full[0];
   assign prod_1 = full[1];
   assign prod_2 = full[2];
   assign prod_3 = full[3];
endmodule : aos_mult_model
`default_nettype wire

/* File: testbench.sv */
/*
 * testbench: self-checking bench for the adder/output stage, with the
 * multiplier model in front and an apb master for configuration.
 * assumes: zero-wait apb slave, 25 MHz mclk, products from aos_mult_model.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; $display("mismatch at %0t: value differs", $time); end end
module testbench;
   import aos_pkg::*;
   // ----------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------
   localparam int LIMIT = 5000;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [AW-1:0] paddr = '0;
   logic [DW-1:0] pwdata = '0;
   logic [DW-1:0] prdata;
   logic pready;
   logic pslverr;
   logic [PW-1:0] prod_0, prod_1, prod_2, prod_3;
   logic [3:0][HW-1:0] op_a = '0;
   logic [3:0][HW-1:0] op_b = '0;
   logic sign_a = 1'b0;
   logic sign_b = 1'b0;
   logic [1:0] addnsub = 2'h0;
   logic [1:0] sload = 2'h0;
   logic [3:0] ena = 4'hf;
   logic [3:0] clr = 4'h0;
   logic [OUT_W-1:0] result;
   logic [1:0] overflow;
   logic [3:0][PW-1:0] pe;
   logic [3:0][PW-1:0] lx;
   logic se;
   logic [1:0] ae;
   logic [3:0] ee;
   logic [3:0] ce;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   aos_mult_model aos_mult_model_inst (.op_a, .op_b, .sign_a, .sign_b,
      .prod_0, .prod_1, .prod_2, .prod_3);
   aos_adder_output_stage aos_adder_output_stage_inst (.mclk, .rst_b, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .prod_0, .prod_1, .prod_2,
      .prod_3, .sign_a, .sign_b, .addnsub, .sload, .ena, .clr, .result, .overflow);
   always #20 mclk = ~mclk;
   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [PW-1:0] mul(input logic [HW-1:0] a, input logic [HW-1:0] b,
                                         input logic sa, input logic sb);
      logic [PW-1:0] xa;
      logic [PW-1:0] xb;
      xa = sa ? {{HW{a[HW-1]}}, a} : {{HW{1'b0}}, a};
      xb = sb ? {{HW{b[HW-1]}}, b} : {{HW{1'b0}}, b};
      return PW'(xa * xb);
   endfunction : mul
   function automatic logic [PAIR_W-1:0] ext(input logic [PW-1:0] p, input logic s);
      return s ? {{PW{p[PW-1]}}, p} : {{PW{1'b0}}, p};
   endfunction : ext
   // unsigned unit results wrap at the unit width, not at the lane pair
   function automatic logic [PAIR_W-1:0] fold(input logic [PAIR_W-1:0] x, input logic s);
      return s ? x : {{(PAIR_W-EXT_W){1'b0}}, x[EXT_W-1:0]};
   endfunction : fold
   function automatic logic [PW-1:0] x9(input logic [HW-1:0] h, input logic s);
      return s ? {{HW{h[HW-1]}}, h} : {{HW{1'b0}}, h};
   endfunction : x9
   task automatic results();
      if (mismatches == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      output logic [DW-1:0] q, output logic e);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // no wait count assumed; the cycle limit catches a hang
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // random operands with the extreme codes mixed in
   task automatic drive(input logic rnd_ctl);
      logic [3:0][HW-1:0] a;
      logic [3:0][HW-1:0] b;
      logic sa;
      logic sb;
      @(posedge mclk);
      for (int k = 0; k < 4; k++) begin
         a[k] = ($urandom % 4 == 0) ? 18'h20000 : 18'($urandom);
         b[k] = ($urandom % 4 == 0) ? 18'h3ffff : 18'($urandom);
      end
      sa = 1'($urandom);
      sb = 1'($urandom);
      ae = 2'($urandom);
      ee = rnd_ctl ? 4'($urandom) : 4'hf;
      ce = rnd_ctl ? 4'($urandom & $urandom & $urandom) : 4'h0;
      for (int k = 0; k < 4; k++)
         pe[k] = mul(a[k], b[k], sa, sb);
      se = sa | sb;
      op_a <= a;
      op_b <= b;
      sign_a <= sa;
      sign_b <= sb;
      addnsub <= ae;
      ena <= ee;
      clr <= ce;
   endtask : drive
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         results();
      end
   end
   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      logic [DW-1:0] q;
      logic e;
      logic [PAIR_W-1:0] u0;
      logic [PAIR_W-1:0] u1;
      logic [1:0][ACC_W-1:0] acc;
      logic [ACC_W-1:0] p;
      logic [1:0] sl;
      logic [1:0] ad;
      logic [1:0] d1;
      logic [1:0] d2;
      logic [3:0][HW-1:0] a;
      logic [3:0][HW-1:0] b;
      logic ov;
      void'($urandom(32'h2890));
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0, q, e);
      `CHK(q, {24'h0, CTRL_RST})
      apb(1'b0, OFS_PIPE, 32'h0, q, e);
      `CHK(q, {16'h0, PIPE_RST})
      apb(1'b0, 8'h0c, 32'h0, q, e);
      `CHK(e, 1'b1)
      `CHK(q, 32'h0)
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, OFS_CTRL, 32'(m), q, e);
         apb(1'b0, OFS_STAT, 32'h0, q, e);
         `CHK(q, 32'(4 << m))
      end
      apb(1'b1, OFS_CTRL, 32'h0, q, e);
      repeat (20) begin
         drive(1'b1);
         @(negedge mclk);
         `CHK(result, pe)
      end
      for (int m = 2; m < 4; m++) begin
         apb(1'b1, OFS_CTRL, 32'(m), q, e);
         repeat (20) begin
            drive(1'b0);
            @(negedge mclk);
            u0 = ae[0] ? ext(pe[0], se) + ext(pe[1], se) : ext(pe[0], se) - ext(pe[1], se);
            u1 = ae[1] ? ext(pe[2], se) + ext(pe[3], se) : ext(pe[2], se) - ext(pe[3], se);
            u0 = fold(u0, se);
            u1 = fold(u1, se);
            if (m == 2) begin
               `CHK(result[71:0], u0)
               `CHK(result[143:72], u1)
            end else
               `CHK(result[71:0], fold(u0 + u1, se))
         end
      end
      apb(1'b1, OFS_CTRL, 32'hf0, q, e);
      for (int i = 0; i < 25; i++) begin
         drive(i > 0);
         @(negedge mclk);
         if (i > 0)
            `CHK(result, lx)
         for (int k = 0; k < 4; k++)
            lx[k] = ce[k] ? 36'h0 : ee[k] ? pe[k] : lx[k];
      end
      // tail of the run forces a borrow out of the accumulator, then clears it
      apb(1'b1, OFS_CTRL, 32'h1, q, e);
      ov = 1'b0;
      for (int i = 0; i < 34; i++) begin
         @(posedge mclk);
         a = '0;
         b = '0;
         sl = (i == 0 || i == 30) ? 2'b11 :
              (i > 30) ? 2'b00 : 2'(($urandom % 5 == 0) ? $urandom : 0);
         ad = (i == 31) ? 2'b00 : (i > 31) ? 2'b11 : 2'($urandom);
         a[1] = (i == 30) ? 18'h5 : (i == 31) ? 18'ha : (i > 31) ? 18'h1 : 18'($urandom);
         b[1] = (i >= 30) ? 18'h1 : 18'($urandom);
         a[3] = 18'($urandom);
         b[3] = 18'($urandom);
         sload <= sl;
         addnsub <= ad;
         sign_a <= 1'b0;
         sign_b <= 1'b0;
         ena <= 4'hf;
         clr <= 4'h0;
         op_a <= a;
         op_b <= b;
         @(negedge mclk);
         if (i > 0) begin
            `CHK(result[51:0], acc[0])
            `CHK(result[123:72], acc[1])
         end
         if (i > 30)
            `CHK(overflow[0], ov)
         for (int k = 0; k < 2; k++) begin
            p = {16'h0, mul(a[2 * k + 1], b[2 * k + 1], 1'b0, 1'b0)};
            acc[k] = sl[k] ? p : ad[k] ? acc[k] + p : acc[k] - p;
         end
         ov = (i == 31);
      end
      // wide product from unsigned halves spread over the sub-blocks
      apb(1'b1, OFS_CTRL, 32'h8, q, e);
      repeat (8) begin
         @(posedge mclk);
         u0 = {36'h0, 36'({$urandom, $urandom})};
         u1 = {36'h0, 36'({$urandom, $urandom})};
         for (int k = 0; k < 4; k++) begin
            a[k] = k[0] ? u0[35:18] : u0[17:0];
            b[k] = k[1] ? u1[35:18] : u1[17:0];
         end
         op_a <= a;
         op_b <= b;
         @(negedge mclk);
         `CHK(result, {72'h0, u0 * u1})
      end
      // nine-bit pairs, select delayed two steps behind the products
      apb(1'b1, OFS_PIPE, 32'he402, q, e);
      apb(1'b1, OFS_CTRL, 32'h6, q, e);
      d1 = ad;
      d2 = ad;
      repeat (12) begin
         drive(1'b0);
         @(negedge mclk);
         for (int k = 0; k < 4; k++) begin
            lx[k] = d2[k / 2] ? x9(pe[k][17:0], se) + x9(pe[k][35:18], se) :
                    x9(pe[k][17:0], se) - x9(pe[k][35:18], se);
            `CHK(result[PW * k +: PW], lx[k])
         end
         d2 = d1;
         d1 = ae;
      end
      results();
   end
endmodule : testbench
`default_nettype wire
